/* rtl/fpc_pcs.v */
/*
  Digital coding path of a 100 Mbps twisted-pair port: 4B/5B, scrambler,
  NRZI and three-level coding on transmit; the reverse plus delimiter
  alignment and receive status on the MAC-facing side.
  Assumes line levels come from recovery logic outside this clock domain and
  that the MAC paces transmit nibbles with valid and ready.
*/
`include "fpc_regs.vh"

// Behaviour
// - Unused code groups in frame raise error
// - Scrambler seed taken from management address
// - Scrambler stage serialises five-bit groups
// - Scrambled bits become NRZI serial stream
// - One bit steps three-level output onward
// - Transmit logic runs on line bit rate
// - Three-level input turned back into NRZI
// - Descrambler inverts key and deserialises
// - Key acquired on idle, then held
// - No idle within window restarts sync
// - Group alignment set on start delimiter
// - Start delimiter shown as two 0101 nibbles
// - Data valid rises with first delimiter nibble
// - End delimiter or two idles end frame
// - Valid held until end, link, signal or lock loss
// - Non-data groups in frame flag error, except K (shown as 0101) and the T-R or idle-idle end pairs
// - Bad start delimiter drives 1110 with error
// - Nibbles at one-fifth bit rate, free when idle
// - Data nibbles mapped by fixed table
// - Rising enable sends start delimiter pair
// - Falling enable sends end pair, then idle
// - Transmit error sends error code group
module fpc_pcs #(
  parameter BIT_DIV       = 1,
  parameter FIFO_DEPTH    = 8,
  parameter IDLE_WIN_BITS = `FPC_WIN_BYTES * `FPC_BITS_PER_BYTE
) (
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       nrst_i,
  // Configuration
  input  wire [4:0] phy_mgmt_addr_i,
  // MII transmit from MAC
  input  wire       tx_valid_i,
  output wire       tx_ready_o,
  input  wire       tx_en_i,
  input  wire       tx_er_i,
  input  wire [3:0] txd_i,
  // Line transmit
  output reg  [1:0] tx_lvl_o,
  // Line receive
  input  wire [1:0] rx_lvl_i,
  input  wire       line_signal_present_i,
  input  wire       link_ok_i,
  // MII receive to MAC
  output reg        rx_stb_o,
  output reg  [3:0] rxd_o,
  output reg        rx_dv_o,
  output reg        rx_er_o,
  output reg        crs_o
);

  localparam TX_IDLE = 3'h0;
  localparam TX_K    = 3'h1;
  localparam TX_DATA = 3'h2;
  localparam TX_R    = 3'h3;

  function [4:0] enc_nib;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: enc_nib = 5'h1e;
        4'h1: enc_nib = 5'h09;
        4'h2: enc_nib = 5'h14;
        4'h3: enc_nib = 5'h15;
        4'h4: enc_nib = 5'h0a;
        4'h5: enc_nib = 5'h0b;
        4'h6: enc_nib = 5'h0e;
        4'h7: enc_nib = 5'h0f;
        4'h8: enc_nib = 5'h12;
        4'h9: enc_nib = 5'h13;
        4'ha: enc_nib = 5'h16;
        4'hb: enc_nib = 5'h17;
        4'hc: enc_nib = 5'h1a;
        4'hd: enc_nib = 5'h1b;
        4'he: enc_nib = 5'h1c;
        default: enc_nib = 5'h1d;
      endcase
    end
  endfunction

  // Returns {is_data, nibble}; every unused group decodes as not data
  function [4:0] dec_cg;
    input [4:0] cg;
    reg   [3:0] n;
    reg         hit;
    integer     i;
    begin
      n   = 4'h0;
      hit = 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        if (enc_nib(i[3:0]) == cg) begin
          n   = i[3:0];
          hit = 1'b1;
        end
      end
      dec_cg = {hit, n};
    end
  endfunction

  function key_fb;
    input [`FPC_KEY_BITS-1:0] k;
    begin
      key_fb = k[10] ^ k[8];
    end
  endfunction

  // Bit-rate enable
  reg  [7:0] div_cnt;
  wire       bit_en;
  assign bit_en = (div_cnt == BIT_DIV - 1);

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= bit_en ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // Transmit buffer
  wire [5:0] fifo_q;
  wire       fifo_valid;
  reg        fifo_pop;

  fpc_fifo #(
    .WIDTH (6),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_tx_fifo (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   ({tx_en_i, tx_er_i, txd_i}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_q)
  );

  // Transmit symbol sequencer
  reg  [2:0]                tx_state;
  reg  [2:0]                next_tx_state;
  reg  [4:0]                next_cg;
  reg  [2:0]                tx_bit_cnt;
  reg  [4:0]                tx_shift;
  reg  [`FPC_KEY_BITS-1:0]  tx_key;
  reg                       seeded;
  reg                       tx_nrzi;
  reg  [1:0]                tx_phase;
  wire                      sym_edge;
  wire                      head_en;
  wire                      tx_scr_bit;

  assign sym_edge   = bit_en && (tx_bit_cnt == `FPC_SYM_LAST);
  assign head_en    = fifo_valid && fifo_q[5];
  assign tx_scr_bit = tx_shift[4] ^ key_fb(tx_key);

  always @* begin
    next_tx_state = tx_state;
    next_cg       = `FPC_CG_IDLE;
    fifo_pop      = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        fifo_pop = sym_edge && fifo_valid;
        if (head_en) begin
          next_cg       = `FPC_CG_SSD_J;
          next_tx_state = TX_K;
        end
      end
      TX_K: begin
        fifo_pop      = sym_edge && head_en;
        next_cg       = `FPC_CG_SSD_K;
        next_tx_state = TX_DATA;
      end
      TX_DATA: begin
        if (head_en) begin
          fifo_pop = sym_edge;
          next_cg  = fifo_q[4] ? `FPC_CG_TX_ERR : enc_nib(fifo_q[3:0]);
        end else begin
          next_cg       = `FPC_CG_ESD_T;
          next_tx_state = TX_R;
        end
      end
      TX_R: begin
        next_cg       = `FPC_CG_ESD_R;
        next_tx_state = TX_IDLE;
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_state   <= TX_IDLE;
      tx_bit_cnt <= 3'h0;
      tx_shift   <= `FPC_CG_IDLE;
      tx_key     <= {`FPC_KEY_BITS{1'b1}};
      seeded     <= 1'b0;
      tx_nrzi    <= 1'b0;
      tx_phase   <= 2'h0;
      tx_lvl_o   <= `FPC_LVL_ZERO;
    end else begin
      if (!seeded) begin
        seeded <= 1'b1;
        tx_key <= {phy_mgmt_addr_i, `FPC_SEED_LOW};
      end else if (bit_en) begin
        tx_key <= {tx_key[9:0], key_fb(tx_key)};
        if (sym_edge) begin
          tx_bit_cnt <= 3'h0;
          tx_state   <= next_tx_state;
          tx_shift   <= next_cg;
        end else begin
          tx_bit_cnt <= tx_bit_cnt + 3'h1;
          tx_shift   <= {tx_shift[3:0], 1'b0};
        end
        tx_nrzi <= tx_nrzi ^ tx_scr_bit;
        if (tx_scr_bit) begin
          tx_phase <= tx_phase + 2'h1;
          case (tx_phase)
            2'h0:    tx_lvl_o <= `FPC_LVL_PLUS;
            2'h2:    tx_lvl_o <= `FPC_LVL_MINUS;
            default: tx_lvl_o <= `FPC_LVL_ZERO;
          endcase
        end
      end
    end
  end

  // Input synchronisers
  reg [1:0] lvl_m;
  reg [1:0] lvl_s;
  reg [1:0] sig_m;
  reg [1:0] sig_s;

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lvl_m <= `FPC_LVL_ZERO;
      lvl_s <= `FPC_LVL_ZERO;
      sig_m <= 2'h0;
      sig_s <= 2'h0;
    end else begin
      lvl_m <= rx_lvl_i;
      lvl_s <= lvl_m;
      sig_m <= {line_signal_present_i, link_ok_i};
      sig_s <= sig_m;
    end
  end

  // Receive path
  reg  [1:0]               rx_lvl_prev;
  reg                      rx_nrzi;
  reg  [`FPC_KEY_BITS-1:0] rx_key;
  reg                      locked;
  reg  [5:0]               ones_run;
  reg  [15:0]              win_cnt;
  reg  [14:0]              win;
  reg  [2:0]               rx_sym_cnt;
  reg                      in_frame;
  reg  [4:0]               hold_cg;
  wire                     rx_bit;
  wire                     rx_db;
  wire [14:0]              nwin;
  wire                     line_ok;
  wire                     rx_edge;
  wire [4:0]               new_cg;
  wire [4:0]               hold_dec;

  assign rx_bit   = (lvl_s != rx_lvl_prev);
  assign rx_db    = rx_bit ^ key_fb(rx_key);
  assign nwin     = {win[13:0], rx_db};
  assign line_ok  = sig_s[1] && sig_s[0] && locked;
  assign rx_edge  = bit_en && (rx_sym_cnt == `FPC_SYM_LAST);
  assign new_cg   = nwin[4:0];
  assign hold_dec = dec_cg(hold_cg);

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_lvl_prev <= `FPC_LVL_ZERO;
      rx_nrzi     <= 1'b0;
      rx_key      <= {`FPC_KEY_BITS{1'b0}};
      locked      <= 1'b0;
      ones_run    <= 6'h00;
      win_cnt     <= 16'h0000;
      win         <= 15'h0000;
      rx_sym_cnt  <= 3'h0;
      in_frame    <= 1'b0;
      hold_cg     <= `FPC_CG_IDLE;
      rx_stb_o    <= 1'b0;
      rxd_o       <= 4'h0;
      rx_dv_o     <= 1'b0;
      rx_er_o     <= 1'b0;
      crs_o       <= 1'b0;
    end else begin
      rx_stb_o <= 1'b0;
      if (bit_en) begin
        rx_lvl_prev <= lvl_s;
        rx_nrzi     <= rx_nrzi ^ rx_bit;
        win         <= nwin;
        rx_key      <= {rx_key[9:0], locked ? key_fb(rx_key) : ~rx_bit};
        ones_run    <= rx_db ? ((ones_run == 6'h3f) ? ones_run : ones_run + 6'h01) : 6'h00;
        rx_sym_cnt  <= rx_edge ? 3'h0 : rx_sym_cnt + 3'h1;
        if (!locked) begin
          win_cnt <= 16'h0000;
          if (ones_run >= `FPC_LOCK_ONES) begin
            locked <= 1'b1;
          end
        end else if (ones_run >= `FPC_IDLE_ONES) begin
          win_cnt <= 16'h0000;
        end else if (win_cnt >= IDLE_WIN_BITS - 1) begin
          locked <= 1'b0;
        end else begin
          win_cnt <= win_cnt + 16'h0001;
        end
        if (in_frame && !line_ok) begin
          in_frame <= 1'b0;
          rx_dv_o  <= 1'b0;
          rx_er_o  <= 1'b0;
          crs_o    <= 1'b0;
          rx_stb_o <= 1'b1;
        end else if (!in_frame && line_ok && nwin[9:0] == {`FPC_CG_SSD_J, `FPC_CG_SSD_K}) begin
          in_frame   <= 1'b1;
          rx_sym_cnt <= 3'h0;
          hold_cg    <= `FPC_CG_SSD_K;
          rxd_o      <= `FPC_NIB_PREAMBLE;
          rx_dv_o    <= 1'b1;
          rx_er_o    <= 1'b0;
          crs_o      <= 1'b1;
          rx_stb_o   <= 1'b1;
        end else if (!in_frame && line_ok && nwin[14:5] == {`FPC_CG_IDLE, `FPC_CG_SSD_J}
                     && new_cg != `FPC_CG_SSD_K) begin
          rxd_o    <= `FPC_NIB_BAD_SSD;
          rx_er_o  <= 1'b1;
          rx_dv_o  <= 1'b0;
          rx_stb_o <= 1'b1;
        end else if (rx_edge) begin
          rx_stb_o <= 1'b1;
          if (!in_frame) begin
            rx_er_o <= 1'b0;
            rx_dv_o <= 1'b0;
            crs_o   <= 1'b0;
          end else begin
            hold_cg <= new_cg;
            if ((hold_cg == `FPC_CG_ESD_T && new_cg == `FPC_CG_ESD_R) ||
                (hold_cg == `FPC_CG_IDLE && new_cg == `FPC_CG_IDLE)) begin
              in_frame <= 1'b0;
              rx_dv_o  <= 1'b0;
              rx_er_o  <= 1'b0;
              crs_o    <= 1'b0;
            end else if (hold_cg == `FPC_CG_SSD_K) begin
              rxd_o   <= `FPC_NIB_PREAMBLE;
              rx_er_o <= 1'b0;
            end else begin
              rxd_o   <= hold_dec[3:0];
              rx_er_o <= ~hold_dec[4];
            end
          end
        end
      end
    end
  end

endmodule

/* rtl/fpc_regs.vh */
/*
  Constants of the fast ethernet coding path: code groups, line levels,
  scrambler and synchroniser figures.
  Assumes inclusion by bare name from rtl/ and a single clock domain.
*/
`ifndef FPC_REGS_VH
`define FPC_REGS_VH

// Special code groups
`define FPC_CG_IDLE     5'h1f
`define FPC_CG_SSD_J    5'h18
`define FPC_CG_SSD_K    5'h11
`define FPC_CG_ESD_T    5'h0d
`define FPC_CG_ESD_R    5'h07
`define FPC_CG_TX_ERR   5'h04

// Nibbles driven to the MAC
`define FPC_NIB_PREAMBLE 4'h5
`define FPC_NIB_BAD_SSD  4'he

// Three-level line codes
`define FPC_LVL_ZERO    2'h0
`define FPC_LVL_PLUS    2'h1
`define FPC_LVL_MINUS   2'h3

// Code group geometry
`define FPC_SYM_BITS    5
`define FPC_SYM_LAST    3'h4

// Scrambler key generator
`define FPC_KEY_BITS    11
`define FPC_SEED_LOW    6'h2d

// Descrambler lock and idle window
`define FPC_LOCK_ONES   6'h1e
`define FPC_IDLE_ONES   6'h0a
`define FPC_WIN_BYTES   4000
`define FPC_WIN_US      40
`define FPC_BITS_PER_BYTE 8

// Rates
`define FPC_LINE_MHZ    125
`define FPC_MII_MHZ     25

`endif

/* rtl/fpc_fifo.v */
/*
  Parameterised synchronous FIFO with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset; flags are registered.
*/
module fpc_fifo #(
  parameter WIDTH = 6,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             nrst_i,
  // Filling side
  input  wire             in_valid_i,
  output reg              in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Draining side
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      next_count = count - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr      <= {AW{1'b0}};
      rd_ptr      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      count       <= next_count;
      in_ready_o  <= (next_count != DEPTH);
      out_valid_o <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule

/* tb/fpc_pcs_assertions.sv */
/*
  Checker on the fpc_pcs ports: line levels and receive status.
  Assumes one clock domain and BIT_DIV of 1.
*/
module fpc_pcs_chk (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  // Line
  input wire logic [1:0] tx_lvl_o,
  input wire logic       line_signal_present_i,
  // Receive status
  input wire logic       rx_stb_o,
  input wire logic [3:0] rxd_o,
  input wire logic       rx_dv_o,
  input wire logic       rx_er_o,
  input wire logic       crs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_nz;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // Last nonzero line level
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      last_nz <= 2'h3;
    else if (tx_lvl_o != 2'h0)
      last_nz <= tx_lvl_o;

  sequence s_gap4;
    !rx_stb_o [*4];
  endsequence
  sequence s_pre;
    rx_stb_o && rx_dv_o && rxd_o == 4'h5;
  endsequence

  chk_lvl_code: assert property (tx_lvl_o != 2'h2)
    else $error("unused line level code");
  chk_lvl_step: assert property (
    $past(tx_lvl_o) != 2'h0 && tx_lvl_o != $past(tx_lvl_o) |-> tx_lvl_o == 2'h0)
    else $error("line level skipped zero");
  chk_lvl_alt: assert property (
    $past(tx_lvl_o) == 2'h0 && tx_lvl_o != 2'h0 |-> tx_lvl_o != last_nz)
    else $error("line level did not alternate");
  chk_out_sync: assert property (
    $changed({rxd_o, rx_dv_o, rx_er_o, crs_o}) |-> rx_stb_o)
    else $error("receive outputs moved off strobe");
  chk_dv_crs: assert property (rx_dv_o |-> crs_o)
    else $error("valid without carrier");
  chk_dv_first: assert property ($rose(rx_dv_o) |-> rxd_o == 4'h5 && !rx_er_o)
    else $error("first valid nibble not preamble");
  chk_pre_twice: assert property ($rose(rx_dv_o) |=> s_gap4 ##1 s_pre)
    else $error("second preamble nibble missing");
  chk_dv_gap: assert property (
    rx_stb_o && rx_dv_o |=> !(rx_stb_o && rx_dv_o) [*4])
    else $error("valid nibbles closer than a group");
  chk_bad_ssd: assert property (rx_er_o && !rx_dv_o |-> rxd_o == 4'he)
    else $error("bad delimiter nibble wrong");
  chk_sig_loss: assert property (
    $fell(line_signal_present_i) |-> ##[1:8] !rx_dv_o && !crs_o)
    else $error("valid held after signal loss");
endmodule

bind fpc_pcs fpc_pcs_chk u_chk (.sys_clk_i, .nrst_i, .tx_lvl_o,
  .line_signal_present_i, .rx_stb_o, .rxd_o, .rx_dv_o, .rx_er_o, .crs_o);

/* tb/fpc_mac_model.sv */
/*
  MAC side model: offers nibble entries by valid and ready, collects
  received nibbles. Assumes the bench calls put and stop after a clock edge.
*/
module fpc_mac_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Transmit offer
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  output logic            tx_en_o,
  output logic            tx_er_o,
  output logic [3:0]      txd_o,
  // Receive capture
  input  wire logic       rx_stb_i,
  input  wire logic [3:0] rxd_i,
  input  wire logic       rx_dv_i,
  input  wire logic       rx_er_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] got [$];
  logic       dv_seen = 1'b0;
  int         n_stall = 0;
  int         n_hang = 0;
  int         gap = 0;

  initial
    {tx_valid_o, tx_en_o, tx_er_o, txd_o} = 7'h00;

  // One entry held until taken or 64 stall cycles pass, then optional idle gap
  task automatic put(input logic er, input logic [3:0] d);
    int n;
    tx_valid_o <= 1'b1;
    tx_en_o <= 1'b1;
    tx_er_o <= er;
    txd_o <= d;
    @(posedge sys_clk_i);
    for (n = 0; n < 64 && tx_ready_i !== 1'b1; n++) begin
      n_stall++;
      @(posedge sys_clk_i);
    end
    if (n == 64)
      n_hang++;
    if (gap > 0) begin
      tx_valid_o <= 1'b0;
      repeat (gap) @(posedge sys_clk_i);
    end
  endtask

  task automatic stop();
    tx_valid_o <= 1'b0;
    tx_en_o <= 1'b0;
  endtask

  always @(posedge sys_clk_i) begin
    if (rx_dv_i === 1'b1)
      dv_seen <= 1'b1;
    if (rx_stb_i === 1'b1 && rx_dv_i === 1'b1)
      got.push_back({rx_er_i, rxd_i});
  end
endmodule

/* tb/fpc_pcs_tb.sv */
/*
  Bench for fpc_pcs: line output looped back into the receiver, frames
  offered by the MAC model. Assumes BIT_DIV of 1 and a short idle window.
*/
module fpc_pcs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 200;
  logic       sys_clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic [4:0] phy_mgmt_addr_i = 5'h01;
  logic [1:0] rx_lvl_i = 2'h0;
  logic       line_signal_present_i = 1'b1;
  logic       link_ok_i = 1'b1;
  logic [1:0] cut_val = 2'h3;
  logic       flip = 1'b0;
  logic [1:0] lvl_q = 2'h0;
  wire        tx_valid_i, tx_ready_o, tx_en_i, tx_er_i;
  wire  [3:0] txd_i, rxd_o;
  wire  [1:0] tx_lvl_o;
  wire        rx_stb_o, rx_dv_o, rx_er_o, crs_o;
  int         n_fail = 0;
  int         n_tests = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  // Line looped back; flip inverts every received bit
  always @(posedge sys_clk_i) begin
    lvl_q <= tx_lvl_o;
    if (!flip)
      rx_lvl_i <= tx_lvl_o;
    else if (tx_lvl_o == lvl_q)
      rx_lvl_i <= (rx_lvl_i == 2'h0) ? 2'h1 : 2'h0;
  end

  fpc_pcs #(.BIT_DIV(1), .FIFO_DEPTH(8), .IDLE_WIN_BITS(WIN)) u_dut (
    .sys_clk_i, .nrst_i, .phy_mgmt_addr_i, .tx_valid_i, .tx_ready_o,
    .tx_en_i, .tx_er_i, .txd_i, .tx_lvl_o, .rx_lvl_i, .line_signal_present_i,
    .link_ok_i, .rx_stb_o, .rxd_o, .rx_dv_o, .rx_er_o, .crs_o);
  fpc_mac_model u_mac (.sys_clk_i, .tx_valid_o(tx_valid_i), .tx_ready_i(tx_ready_o),
    .tx_en_o(tx_en_i), .tx_er_o(tx_er_i), .txd_o(txd_i), .rx_stb_i(rx_stb_o),
    .rxd_i(rxd_o), .rx_dv_i(rx_dv_o), .rx_er_i(rx_er_o));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset(input logic [4:0] a);
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    phy_mgmt_addr_i <= a;
    repeat (12) @(posedge sys_clk_i);
    chk("reset_outputs", 8'h00, {5'h00, tx_lvl_o, tx_ready_o});
    nrst_i <= 1'b1;
  endtask

  // Two delimiter slots, n nibbles, then wait for the frame to end
  task automatic send(input int n, input int er_at, input int cut);
    int k;
    u_mac.got.delete();
    u_mac.dv_seen = 1'b0;
    u_mac.n_stall = 0;
    u_mac.put(1'b0, 4'h5);
    u_mac.put(1'b0, 4'h5);
    for (k = 0; k < n; k++) begin
      if (k == cut)
        {line_signal_present_i, link_ok_i} <= cut_val;
      u_mac.put(k == er_at, k[3:0]);
    end
    u_mac.stop();
    for (k = 0; k < 2000 && !(u_mac.dv_seen && crs_o === 1'b0); k++)
      @(posedge sys_clk_i);
    if (k == 2000 || u_mac.n_hang != 0) begin
      n_fail++;
      $display("[ERR] frame_wait exp done seen timeout");
      test_done();
    end
    {line_signal_present_i, link_ok_i} <= 2'h3;
    repeat (120) @(posedge sys_clk_i);
  endtask

  task automatic t_seed();
    logic [127:0] s [2];
    for (int a = 0; a < 2; a++) begin
      do_reset(a ? 5'h02 : 5'h01);
      for (int c = 0; c < 64; c++) begin
        @(posedge sys_clk_i);
        s[a] = {s[a][125:0], tx_lvl_o};
      end
    end
    chk("seed_streams_differ", 8'h01, {7'h00, s[0] != s[1]});
  endtask

  task automatic t_frame();
    send(16, -1, -1);
    chk("nibble_count", 8'h12, 8'(u_mac.got.size()));
    chk("fifo_refused", 8'h01, {7'h00, u_mac.n_stall > 0});
    for (int k = 0; k < 18; k++)
      chk("rx_nibble", k < 2 ? 8'h05 : 8'(k - 2), {3'h0, u_mac.got[k]});
  endtask

  task automatic t_err();
    u_mac.gap = 2;
    send(6, 3, -1);
    u_mac.gap = 0;
    chk("err_flag", 8'h01, {7'h00, u_mac.got[5][4]});
    chk("after_err", 8'h04, {3'h0, u_mac.got[6]});
  endtask

  task automatic t_window();
    send(48, -1, -1);
    chk("window_abort", 8'h01, {7'h00, u_mac.got.size() < 50});
  endtask

  task automatic t_loss();
    for (int w = 0; w < 2; w++) begin
      cut_val = w ? 2'h2 : 2'h1;
      send(20, -1, 16);
      chk("loss_cut", 8'h01, {7'h00, u_mac.got.size() < 22});
      chk("loss_dv", 8'h00, {7'h00, rx_dv_o});
    end
  endtask

  // Second delimiter group inverted on the line
  task automatic t_bad_ssd();
    int k;
    u_mac.dv_seen = 1'b0;
    fork
      begin
        u_mac.put(1'b0, 4'h5);
        u_mac.put(1'b0, 4'h5);
        for (k = 0; k < 4; k++)
          u_mac.put(1'b0, 4'h3);
        u_mac.stop();
      end
      begin
        for (int w = 0; w < 200 && u_dut.tx_state !== 3'h2; w++)
          @(posedge sys_clk_i);
        flip <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        flip <= 1'b0;
      end
    join
    for (k = 0; k < 60 && !(rx_er_o === 1'b1 && rx_dv_o === 1'b0); k++)
      @(posedge sys_clk_i);
    chk("bad_ssd_er", 8'h01, {7'h00, rx_er_o});
    chk("bad_ssd_rxd", 8'h0e, {4'h0, rxd_o});
    repeat (120) @(posedge sys_clk_i);
    chk("bad_ssd_dv", 8'h00, {7'h00, u_mac.dv_seen});
  endtask

  initial begin
    t_seed();
    repeat (80) @(posedge sys_clk_i);
    t_frame();
    t_err();
    t_window();
    t_frame();
    t_loss();
    t_bad_ssd();
    test_done();
  end
endmodule
